/* File: inc/dlb_pkg.sv */
/*
 * package for the divide and loop-branch execution block: opcodes,
 * postbyte fields, counter selects, flag positions, timing counts.
 * assumes a single core clock domain; no other surroundings.
 */
package dlb_pkg;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int DLB_W        = 16;              // data path width
   localparam int DLB_OFS_W    = 9;               // loop offset width
   // ----------------------------------------------------------------
   // opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] DLB_PAGE2_BYTE   = 8'h18;  // divide prefix
   localparam logic [7:0] DLB_INT_DIV_BYTE = 8'h10;  // integer divide
   localparam logic [7:0] DLB_FRC_DIV_BYTE = 8'h11;  // fraction divide
   localparam logic [7:0] DLB_LOOP_BYTE    = 8'h04;  // loop branch
   // ----------------------------------------------------------------
   // postbyte fields
   // ----------------------------------------------------------------
   localparam int DLB_PB_OP_HI  = 7;              // operation select msb
   localparam int DLB_PB_OP_LO  = 6;              // operation select lsb
   localparam int DLB_PB_NZ_BIT = 5;              // 1 = branch on nonzero
   localparam int DLB_PB_SG_BIT = 0;              // offset sign bit
   localparam int DLB_PB_SEL_HI = 2;              // counter select msb
   localparam logic [1:0] DLB_OP_INC = 2'h2;      // increment pattern 1:0
   localparam logic [2:0] DLB_SEL_A  = 3'h0;      // accumulator a
   localparam logic [2:0] DLB_SEL_B  = 3'h1;      // accumulator b
   localparam logic [2:0] DLB_SEL_D  = 3'h4;      // double accumulator
   localparam logic [2:0] DLB_SEL_X  = 3'h5;      // index x
   localparam logic [2:0] DLB_SEL_Y  = 3'h6;      // index y
   localparam logic [2:0] DLB_SEL_SP = 3'h7;      // stack pointer
   // ----------------------------------------------------------------
   // values and flag positions
   // ----------------------------------------------------------------
   localparam logic [15:0] DLB_ALL_ONES  = 16'hffff; // saturated quotient
   localparam logic [15:0] DLB_ZERO16    = 16'h0000; // zero word
   localparam logic [15:0] DLB_LOOP_LEN  = 16'h0003; // loop instr length
   localparam logic [15:0] DLB_DIV_LEN   = 16'h0002; // divide instr length
   localparam logic [4:0]  DLB_BUSY_LEN  = 5'h11;    // busy cycles: steps plus write-back
   localparam logic [7:0]  DLB_FLAGS_RST = 8'hd0;    // flag word reset
   localparam int DLB_FLG_C = 0;                      // carry
   localparam int DLB_FLG_V = 1;                      // overflow
   localparam int DLB_FLG_Z = 2;                      // zero
   localparam int DLB_DIV_STEPS = 16;                 // one bit per cycle
   localparam logic [4:0] DLB_STEP_LAST = 5'h0f;      // final step index
   // operation select
   typedef enum logic [1:0] {
      DLB_OP_NONE, DLB_OP_INTEGER_DIVIDE_OP, DLB_OP_FRACTION_DIVIDE_OP, DLB_OP_LOOP
   } dlb_op_t;
endpackage : dlb_pkg

/* File: hdl/dlb_divider.sv */
/*
 * dlb_divider: unsigned restoring divider, one quotient bit per cycle.
 * holds the 32-bit numerator as {hi, lo}; integer divide loads hi = 0,
 * fraction divide loads hi = numerator, lo = 0.
 * assumes start is only raised while busy is low.
 */
`timescale 1ns/1ps
module dlb_divider
   import dlb_pkg::*;
(
   input  wire logic         mclk_in,       // core clock
   input  wire logic         rst_in,        // async reset, high
   input  wire logic         start_in,      // one-cycle start
   input  wire logic [15:0]  num_hi_in,     // numerator upper word
   input  wire logic [15:0]  num_lo_in,     // numerator lower word
   input  wire logic [15:0]  den_in,        // divisor
   output logic              done_out,      // one-cycle done
   output logic [15:0]       quo_out,       // quotient
   output logic [15:0]       rem_out        // remainder
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [16:0] rem_reg;                    // partial remainder
   logic [15:0] quo_reg;                    // quotient shift reg
   logic [15:0] den_reg;                    // held divisor
   logic [4:0]  step_reg;                   // step counter
   logic        busy_reg;                   // running
   logic        done_reg;                   // done pulse
   wire  [16:0] shifted  = {rem_reg[15:0], quo_reg[15]};   // shift in bit
   wire  [16:0] trial    = shifted - {1'b0, den_reg};      // trial subtract
   wire         fits     = ~trial[16];                     // subtract kept
   wire         last     = (step_reg == DLB_STEP_LAST);    // final step

   // ----------------------------------------------------------------
   // iteration
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         rem_reg  <= '0;
         quo_reg  <= '0;
         den_reg  <= '0;
         step_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (start_in) begin
         rem_reg  <= {1'b0, num_hi_in};
         quo_reg  <= num_lo_in;
         den_reg  <= den_in;
         step_reg <= '0;
         busy_reg <= 1'b1;
         done_reg <= 1'b0;
      end else if (busy_reg) begin
         rem_reg  <= fits ? trial : shifted;
         quo_reg  <= {quo_reg[14:0], fits};
         step_reg <= step_reg + 5'h1;
         busy_reg <= ~last;
         done_reg <= last;
      end else begin
         done_reg <= 1'b0;
      end
   end

   assign done_out = done_reg;
   assign quo_out  = quo_reg;
   assign rem_out  = rem_reg[15:0];
endmodule : dlb_divider

/* File: hdl/dlb_exec.sv */
/*
 * dlb_exec: executes integer divide, fraction divide and the increment
 * loop branches on an internal register file and flag word.
 * assumes the decoder presents whole instructions on the op ports with
 * a one-cycle valid, only while busy_out is low.
 */
`timescale 1ns/1ps
// Function
// RULE_01: fraction divide: d over x, quotient x
// RULE_02: fraction quotient equals numerator times 2^16 divided
// RULE_03: fraction zero or overflow forces quotient ffff
// RULE_04: fraction flags: z quotient, v overflow, c zero
// RULE_05: integer divide: d over x, quotient x
// RULE_06: integer zero divisor sets carry, quotient ffff
// RULE_07: integer: z quotient, v clear, c divisor zero
// RULE_08: increment counter, branch when now zero
// RULE_09: increment counter, branch when now nonzero
// RULE_10: loop is 04, postbyte, offset; nine bits
// RULE_11: postbyte bit5 picks nonzero, bit0 offset sign
// RULE_12: bits 7:6 equal 1:0 select increment
// RULE_13: bit3 ignored; bits 2:0 select counter
// RULE_14: loop branches leave every flag untouched
module dlb_exec
   import dlb_pkg::*;
(
   input  wire logic                  mclk_in,      // core clock
   input  wire logic                  rst_in,       // async reset, high
   input  wire logic                  issue_in,     // instruction valid
   input  wire logic [7:0]            byte0_in,     // first opcode byte
   input  wire logic [7:0]            byte1_in,     // second byte/postbyte
   input  wire logic [7:0]            byte2_in,     // offset low byte
   input  wire logic [15:0]           pc_in,        // address of instruction
   input  wire logic                  load_in,      // register load strobe
   input  wire logic [15:0]           load_d_in,    // d load value
   input  wire logic [15:0]           load_x_in,    // x load value
   input  wire logic [15:0]           load_y_in,    // y load value
   input  wire logic [15:0]           load_sp_in,   // stack pointer value
   output logic [15:0]                d_out,        // double accumulator
   output logic [15:0]                x_out,        // index x
   output logic [15:0]                y_out,        // index y
   output logic [15:0]                sp_out,       // stack pointer
   output logic [7:0]                 flag_word_out,// flag word
   output logic [15:0]                program_counter_out, // next pc
   output logic                       pc_valid_out, // pc updated pulse
   output logic                       busy_out,     // divide running
   output logic                       illegal_out   // unhandled op pulse
);
   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   dlb_op_t op_sel;                                       // decoded op
   wire is_loop  = (byte0_in == DLB_LOOP_BYTE);           // see RULE_10
   wire is_incr  = (byte1_in[DLB_PB_OP_HI:DLB_PB_OP_LO] == DLB_OP_INC); // see RULE_12
   wire is_page2 = (byte0_in == DLB_PAGE2_BYTE);
   assign op_sel = (is_page2 && byte1_in == DLB_INT_DIV_BYTE) ? DLB_OP_INTEGER_DIVIDE_OP :
                   (is_page2 && byte1_in == DLB_FRC_DIV_BYTE) ? DLB_OP_FRACTION_DIVIDE_OP :
                   (is_loop && is_incr)                      ? DLB_OP_LOOP :
                                                               DLB_OP_NONE;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [15:0] d_reg, x_reg, y_reg, sp_reg;   // register file
   logic [7:0]  flag_reg;                      // flag word
   logic [15:0] pc_reg;                        // program counter out
   logic        pcv_reg;                       // pc pulse
   logic        ill_reg;                       // illegal pulse
   logic        busy_reg;                      // divide running
   logic        frac_reg;                      // running op is fraction
   logic        dz_reg;                        // divisor was zero
   logic        ovf_reg;                       // fraction overflow
   logic [15:0] pc_next_reg;                   // fall-through pc of divide

   // counter read by select; write-back uses its own case on the select
   function automatic logic [15:0] dlb_cnt_read(input logic [2:0] sel,
         input logic [15:0] d, input logic [15:0] x,
         input logic [15:0] y, input logic [15:0] sp);
      unique case (sel)
         DLB_SEL_A:  dlb_cnt_read = {8'h00, d[15:8]};
         DLB_SEL_B:  dlb_cnt_read = {8'h00, d[7:0]};
         DLB_SEL_D:  dlb_cnt_read = d;
         DLB_SEL_X:  dlb_cnt_read = x;
         DLB_SEL_Y:  dlb_cnt_read = y;
         DLB_SEL_SP: dlb_cnt_read = sp;
         default:    dlb_cnt_read = DLB_ZERO16;
      endcase
   endfunction : dlb_cnt_read

   // ----------------------------------------------------------------
   // loop datapath
   // ----------------------------------------------------------------
   wire [2:0]  cnt_sel  = byte1_in[DLB_PB_SEL_HI:0];     // see RULE_13
   wire        byte_cnt = (cnt_sel == DLB_SEL_A) || (cnt_sel == DLB_SEL_B);
   wire        sel_ok   = cnt_sel inside {DLB_SEL_A, DLB_SEL_B, DLB_SEL_D,
                                          DLB_SEL_X, DLB_SEL_Y, DLB_SEL_SP};
   wire [15:0] cnt_old  = dlb_cnt_read(cnt_sel, d_reg, x_reg, y_reg, sp_reg);
   wire [15:0] cnt_new  = cnt_old + 16'h0001;             // see RULE_08
   wire        cnt_zero = byte_cnt ? (cnt_new[7:0] == 8'h00)
                                   : (cnt_new == DLB_ZERO16);
   wire        want_nz  = byte1_in[DLB_PB_NZ_BIT];        // see RULE_11
   wire        take     = want_nz ? ~cnt_zero : cnt_zero; // see RULE_09
   wire [15:0] rel      = {{7{byte1_in[DLB_PB_SG_BIT]}}, byte1_in[DLB_PB_SG_BIT],
                           byte2_in};                     // see RULE_10
   wire [15:0] pc_fall  = pc_in + DLB_LOOP_LEN;
   wire [15:0] pc_loop  = take ? (pc_fall + rel) : pc_fall; // see RULE_08
   wire [15:0] pc_div   = pc_in + DLB_DIV_LEN;            // divide length
   wire        loop_go  = issue_in && !busy_reg && op_sel == DLB_OP_LOOP && sel_ok;
   wire        div_go   = issue_in && !busy_reg &&
                          (op_sel == DLB_OP_INTEGER_DIVIDE_OP || op_sel == DLB_OP_FRACTION_DIVIDE_OP);
   wire        bad_go   = issue_in && !busy_reg && !loop_go && !div_go;

   // ----------------------------------------------------------------
   // divider
   // ----------------------------------------------------------------
   wire        is_frac  = (op_sel == DLB_OP_FRACTION_DIVIDE_OP);
   wire        div_done;
   wire [15:0] div_quo, div_rem;
   dlb_divider u_div (
      .mclk_in   (mclk_in),
      .rst_in    (rst_in),
      .start_in  (div_go),
      .num_hi_in (is_frac ? d_reg : DLB_ZERO16),    // see RULE_02
      .num_lo_in (is_frac ? DLB_ZERO16 : d_reg),    // see RULE_05
      .den_in    (x_reg),
      .done_out  (div_done),
      .quo_out   (div_quo),
      .rem_out   (div_rem)
   );
   wire        sat      = dz_reg || (frac_reg && ovf_reg);        // see RULE_03
   wire [15:0] quo_fin  = sat ? DLB_ALL_ONES : div_quo;           // see RULE_06
   wire [15:0] rem_fin  = sat ? d_reg : div_rem;                  // held if saturated
   wire        z_fin    = (quo_fin == DLB_ZERO16);                // see RULE_04
   wire        v_fin    = frac_reg && ovf_reg;                    // see RULE_07

   // ----------------------------------------------------------------
   // divide bookkeeping
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_reg    <= 1'b0;
         frac_reg    <= 1'b0;
         dz_reg      <= 1'b0;
         ovf_reg     <= 1'b0;
         pc_next_reg <= '0;
      end else if (div_go) begin
         busy_reg    <= 1'b1;
         frac_reg    <= is_frac;
         dz_reg      <= (x_reg == DLB_ZERO16);
         ovf_reg     <= (x_reg <= d_reg);                 // see RULE_04
         pc_next_reg <= pc_div;
      end else if (div_done) begin
         busy_reg    <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // register file, flags and pc
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         d_reg    <= '0;
         x_reg    <= '0;
         y_reg    <= '0;
         sp_reg   <= '0;
         flag_reg <= DLB_FLAGS_RST;
         pc_reg   <= '0;
         pcv_reg  <= 1'b0;
         ill_reg  <= 1'b0;
      end else begin
         pcv_reg <= loop_go || (busy_reg && div_done);
         ill_reg <= bad_go;
         if (load_in && !busy_reg) begin
            d_reg  <= load_d_in;
            x_reg  <= load_x_in;
            y_reg  <= load_y_in;
            sp_reg <= load_sp_in;
         end else if (busy_reg && div_done) begin
            x_reg <= quo_fin;                             // see RULE_01
            d_reg <= rem_fin;                             // see RULE_05
            flag_reg[DLB_FLG_Z] <= z_fin;                 // see RULE_04
            flag_reg[DLB_FLG_V] <= v_fin;                 // see RULE_07
            flag_reg[DLB_FLG_C] <= dz_reg;                // see RULE_06
            pc_reg <= pc_next_reg;
         end else if (loop_go) begin
            // flags left alone here, see RULE_14
            pc_reg <= pc_loop;
            unique case (cnt_sel)
               DLB_SEL_A:  d_reg[15:8] <= cnt_new[7:0];
               DLB_SEL_B:  d_reg[7:0]  <= cnt_new[7:0];
               DLB_SEL_D:  d_reg       <= cnt_new;
               DLB_SEL_X:  x_reg       <= cnt_new;
               DLB_SEL_Y:  y_reg       <= cnt_new;
               default:    sp_reg      <= cnt_new;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   loop_flags_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE_14
      loop_go |=> flag_word_out == $past(flag_reg))
      else $error("loop branch changed flags");
   loop_pc_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE_08
      loop_go && take |=> program_counter_out == $past(pc_in) + DLB_LOOP_LEN + $past(rel))
      else $error("taken loop target wrong");
   loop_fall_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE_09
      loop_go && !take |=> program_counter_out == $past(pc_in) + DLB_LOOP_LEN)
      else $error("fall through target wrong");
   // busy run length; too long for a repetition, so it is counted here
   logic [4:0]  busy_len_reg;                  // busy cycles so far
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_len_reg <= '0;
      end else if (busy_reg) begin
         busy_len_reg <= busy_len_reg + 5'h1;
      end else begin
         busy_len_reg <= '0;
      end
   end
   div_time_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE_05
      $fell(busy_out) |-> busy_len_reg == DLB_BUSY_LEN)
      else $error("divide length wrong");
   div_hang_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE_05
      busy_out |-> busy_len_reg < DLB_BUSY_LEN)
      else $error("divide never finished");
   div_sat_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE_03
      busy_reg && div_done && dz_reg |=> x_out == DLB_ALL_ONES && flag_word_out[DLB_FLG_C])
      else $error("zero divisor not saturated");
   frac_ovf_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE_04
      div_go && is_frac && x_reg <= d_reg |-> ##18 flag_word_out[DLB_FLG_V] && x_out == DLB_ALL_ONES)
      else $error("fraction overflow missed");
   int_vclr_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE_07
      div_go && !is_frac && x_reg != DLB_ZERO16 |-> ##18
      !flag_word_out[DLB_FLG_V] && !flag_word_out[DLB_FLG_C])
      else $error("integer divide flags wrong");
   int_quo_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE_05
      div_go && !is_frac && x_reg != DLB_ZERO16 |-> ##18
      x_out == $past(d_reg, 18) / $past(x_reg, 18))
      else $error("integer quotient wrong");
   div_zflag_a: assert property (@(posedge mclk_in) disable iff (rst_in) // see RULE_04
      busy_reg && div_done |=> flag_word_out[DLB_FLG_Z] == (x_out == DLB_ZERO16))
      else $error("zero flag wrong");

   assign d_out               = d_reg;
   assign x_out               = x_reg;
   assign y_out               = y_reg;
   assign sp_out              = sp_reg;
   assign flag_word_out       = flag_reg;
   assign program_counter_out = pc_reg;
   assign pc_valid_out        = pcv_reg;
   assign busy_out            = busy_reg;
   assign illegal_out         = ill_reg;
endmodule : dlb_exec

/* File: tb/dlb_exec_bench.sv */
/*
 * dlb_exec_bench: self-checking bench for the divide and loop-branch block.
 * assumes dlb_pkg is compiled first; drives every input on the falling edge.
 */
`timescale 1ns/1ps
module dlb_exec_bench;
   import dlb_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        mclk_in = 1'b0;         // core clock, 100 ns
   logic        rst_in  = 1'b1;         // async reset
   logic        issue_in = 1'b0;        // instruction valid
   logic [7:0]  byte0_in = 8'h00;       // opcode byte
   logic [7:0]  byte1_in = 8'h00;       // postbyte
   logic [7:0]  byte2_in = 8'h00;       // offset low byte
   logic [15:0] pc_in = 16'h0100;       // instruction address
   logic        load_in = 1'b0;         // register load strobe
   logic [15:0] load_d_in = 16'h0000;   // load values
   logic [15:0] load_x_in = 16'h0000;
   logic [15:0] load_y_in = 16'hffff;
   logic [15:0] load_sp_in = 16'h1000;
   logic [15:0] d_out, x_out, y_out, sp_out, program_counter_out;
   logic [7:0]  flag_word_out;          // flag word
   logic        pc_valid_out, busy_out, illegal_out;
   int          n_mismatch = 0;         // mismatches seen
   int          checks_done = 0;        // comparisons made
   int          n;                      // wait counter
   logic [7:0]  bad_pb [5] = '{8'h00, 8'h40, 8'hc0, 8'h82, 8'h83}; // unhandled forms
   // one row: postbyte, offset, loaded d/x, expected d/x/y/sp/pc/flags
   typedef struct packed {
      logic [7:0]  b1, b2;
      logic [15:0] d, x, ed, ex, ey, esp, epc;
      logic [7:0]  efl;
   } dlb_row_t;
   dlb_row_t    rw [21];                // ordinary cases

   always #50 mclk_in = ~mclk_in;       // 10 MHz clock

   dlb_exec dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .issue_in(issue_in),
      .byte0_in(byte0_in), .byte1_in(byte1_in), .byte2_in(byte2_in), .pc_in(pc_in),
      .load_in(load_in), .load_d_in(load_d_in), .load_x_in(load_x_in),
      .load_y_in(load_y_in), .load_sp_in(load_sp_in), .d_out(d_out), .x_out(x_out),
      .y_out(y_out), .sp_out(sp_out), .flag_word_out(flag_word_out),
      .program_counter_out(program_counter_out), .pc_valid_out(pc_valid_out),
      .busy_out(busy_out), .illegal_out(illegal_out));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   // compare one value, count and report
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // print counts and verdict, then stop
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report
   // load d and x, y and sp keep their fixed load values
   task automatic load(input logic [15:0] d, input logic [15:0] x);
      @(negedge mclk_in);
      load_in = 1'b1;
      load_d_in = d;
      load_x_in = x;
      @(negedge mclk_in);
      load_in = 1'b0;
   endtask : load
   // one-cycle issue; returns at the falling edge after the taking edge
   task automatic issue(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
      @(negedge mclk_in);
      issue_in = 1'b1;
      byte0_in = b0;
      byte1_in = b1;
      byte2_in = b2;
      @(negedge mclk_in);
      issue_in = 1'b0;
   endtask : issue
   // bounded wait for the pc update pulse
   task automatic wait_done;
      n = 0;
      while (pc_valid_out !== 1'b1 && n < 40) begin
         n++;
         @(negedge mclk_in);
      end
      check("pc_valid", {15'h0000, pc_valid_out}, 16'h0001);
   endtask : wait_done
   // ----------------------------------------------------------------
   // watchdog: the whole run needs well under 2000 cycles
   // ----------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge mclk_in);
      n_mismatch++;
      final_report();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      // divides first, the flag word carries from row to row
      rw[0]  = '{8'h10,8'h00,16'h0007,16'h0002,16'h0001,16'h0003,16'hffff,16'h1000,16'h0102,8'hd0};
      rw[1]  = '{8'h10,8'h00,16'h1234,16'h0000,16'h1234,16'hffff,16'hffff,16'h1000,16'h0102,8'hd1};
      rw[2]  = '{8'h10,8'h00,16'h0003,16'h0005,16'h0003,16'h0000,16'hffff,16'h1000,16'h0102,8'hd4};
      rw[3]  = '{8'h10,8'h00,16'hffff,16'h0001,16'h0000,16'hffff,16'hffff,16'h1000,16'h0102,8'hd0};
      rw[4]  = '{8'h11,8'h00,16'h0001,16'h0002,16'h0000,16'h8000,16'hffff,16'h1000,16'h0102,8'hd0};
      rw[5]  = '{8'h11,8'h00,16'h0001,16'h0003,16'h0001,16'h5555,16'hffff,16'h1000,16'h0102,8'hd0};
      rw[6]  = '{8'h11,8'h00,16'h0005,16'h0005,16'h0005,16'hffff,16'hffff,16'h1000,16'h0102,8'hd2};
      rw[7]  = '{8'h11,8'h00,16'h0000,16'h0005,16'h0000,16'h0000,16'hffff,16'h1000,16'h0102,8'hd4};
      rw[8]  = '{8'h11,8'h00,16'h0000,16'h0000,16'h0000,16'hffff,16'hffff,16'h1000,16'h0102,8'hd3};
      // loops: every counter, both senses, offsets at both ends; z clear, v and c set
      rw[9]  = '{8'h80,8'h05,16'hff12,16'h0000,16'h0012,16'h0000,16'hffff,16'h1000,16'h0108,8'hd3};
      rw[10] = '{8'h91,8'hfe,16'h12ff,16'h0000,16'h1200,16'h0000,16'hffff,16'h1000,16'h0101,8'hd3};
      rw[11] = '{8'h84,8'h10,16'h0005,16'h0000,16'h0006,16'h0000,16'hffff,16'h1000,16'h0103,8'hd3};
      rw[12] = '{8'h95,8'h00,16'h0000,16'hffff,16'h0000,16'h0000,16'hffff,16'h1000,16'h0003,8'hd3};
      rw[13] = '{8'h86,8'hff,16'h0000,16'h0000,16'h0000,16'h0000,16'h0000,16'h1000,16'h0202,8'hd3};
      rw[14] = '{8'h97,8'h01,16'h0000,16'h0000,16'h0000,16'h0000,16'hffff,16'h1001,16'h0103,8'hd3};
      rw[15] = '{8'ha0,8'h10,16'h0112,16'h0000,16'h0212,16'h0000,16'hffff,16'h1000,16'h0113,8'hd3};
      rw[16] = '{8'ha1,8'h10,16'h34ff,16'h0000,16'h3400,16'h0000,16'hffff,16'h1000,16'h0103,8'hd3};
      rw[17] = '{8'ha4,8'hfc,16'h0000,16'h0000,16'h0001,16'h0000,16'hffff,16'h1000,16'h01ff,8'hd3};
      rw[18] = '{8'hb5,8'h20,16'h0000,16'h0010,16'h0000,16'h0011,16'hffff,16'h1000,16'h0023,8'hd3};
      rw[19] = '{8'ha6,8'h20,16'h0000,16'h0000,16'h0000,16'h0000,16'h0000,16'h1000,16'h0103,8'hd3};
      rw[20] = '{8'hbf,8'h80,16'h0000,16'h0000,16'h0000,16'h0000,16'hffff,16'h1001,16'h0083,8'hd3};
      repeat (5) @(negedge mclk_in);
      rst_in = 1'b0;
      // table of ordinary cases
      for (int i = 0; i < 21; i++) begin
         load(rw[i].d, rw[i].x);
         issue(rw[i].b1[7] ? DLB_LOOP_BYTE : DLB_PAGE2_BYTE, rw[i].b1, rw[i].b2);
         wait_done();
         check("d", d_out, rw[i].ed);
         check("x", x_out, rw[i].ex);
         check("y", y_out, rw[i].ey);
         check("sp", sp_out, rw[i].esp);
         check("pc", program_counter_out, rw[i].epc);
         check("flags", {8'h00, flag_word_out}, {8'h00, rw[i].efl});
         $display("row %0d done", i);
      end
      // divide runs 16 steps plus write-back busy; a loop issued meanwhile is ignored
      load(16'h0007, 16'h0002);
      issue(DLB_PAGE2_BYTE, DLB_INT_DIV_BYTE, 8'h00);
      byte0_in = DLB_LOOP_BYTE;
      byte1_in = 8'ha5;
      n = 0;
      while (busy_out === 1'b1 && n < 40) begin
         n++;
         issue_in = (n == 3);
         @(negedge mclk_in);
      end
      issue_in = 1'b0;
      check("busy cycles", n[15:0], {11'h000, DLB_BUSY_LEN});
      check("busy x", x_out, 16'h0003);
      check("busy d", d_out, 16'h0001);
      check("busy pc", program_counter_out, 16'h0102);
      $display("busy test done");
      // two loops on back-to-back edges
      load(16'h0000, 16'h0000);
      @(negedge mclk_in);
      issue_in = 1'b1;
      byte0_in = DLB_LOOP_BYTE;
      byte1_in = 8'ha5;
      byte2_in = 8'h00;
      @(negedge mclk_in);
      check("b2b first", {15'h0000, pc_valid_out}, 16'h0001);
      @(negedge mclk_in);
      issue_in = 1'b0;
      check("b2b second", {15'h0000, pc_valid_out}, 16'h0001);
      check("b2b x", x_out, 16'h0002);
      $display("back to back test done");
      // decrement, test and reserved selects are not executed here
      foreach (bad_pb[k]) begin
         load(16'h1234, 16'h5678);
         issue(DLB_LOOP_BYTE, bad_pb[k], 8'h05);
         check("illegal", {15'h0000, illegal_out}, 16'h0001);
         check("no pc", {15'h0000, pc_valid_out}, 16'h0000);
         check("no d", d_out, 16'h1234);
      end
      $display("unhandled form test done");
      // second reset in mid-run
      @(negedge mclk_in);
      rst_in = 1'b1;
      @(negedge mclk_in);
      check("rst d", d_out, 16'h0000);
      check("rst x", x_out, 16'h0000);
      check("rst sp", sp_out, 16'h0000);
      check("rst flags", {8'h00, flag_word_out}, {8'h00, DLB_FLAGS_RST});
      check("rst busy", {15'h0000, busy_out}, 16'h0000);
      rst_in = 1'b0;
      $display("reset test done");
      final_report();
   end
endmodule : dlb_exec_bench
